// file: logic/oir_pkg.sv
// package for the node id, rom mapping and failed-write capture bank
// assumes 32-bit register port with byte offsets and one clock domain
`default_nettype none
package oir_pkg;

  ///////////////////////////////////////////////////////////////////////
  // register offsets (byte addresses) and reset values
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [7:0] OFS_UID_LOW = 8'h28;
  localparam logic [7:0] OFS_ROM_MAP = 8'h34;
  localparam logic [7:0] OFS_FAIL_LOW = 8'h38;
  localparam logic [7:0] OFS_FAIL_HIGH = 8'h3c;
  localparam logic [7:0] OFS_ORG_CODE = 8'h40;
  localparam logic [31:0] UID_LOW_RST = 32'h0000_0000;
  localparam logic [31:0] ROM_MAP_RST = 32'h0000_0000;
  localparam logic [31:0] FAIL_RST = 32'h0000_0000;
  localparam logic [31:0] RD_UNMAPPED = 32'h0000_0000;

  ///////////////////////////////////////////////////////////////////////
  // rom mapping field and the 1394 window it serves
  localparam int ROM_FIELD_LSB = 10;
  localparam int ROM_FIELD_W = 22;
  localparam int ROM_IDX_W = 10;
  localparam int BUS_OFS_W = 48;
  localparam logic [9:0] ROM_LOW_ZERO = 10'h000;
  localparam logic [47:0] ROM_WIN_LO = 48'hffff_f000_0400;
  localparam logic [47:0] ROM_WIN_HI = 48'hffff_f000_07ff;

  ///////////////////////////////////////////////////////////////////////
  // carriers
  typedef struct packed {
    logic [9:0] bus_num;
    logic [5:0] node_num;
    logic [15:0] dest_offset_upper;
  } oir_fail_high_type;

  typedef struct packed {
    logic valid;
    logic [47:0] offset;
  } oir_rom_req_type;

  typedef struct packed {
    logic valid;
    logic [9:0] bus_num;
    logic [5:0] node_num;
    logic [47:0] offset;
  } oir_fail_type;

  typedef struct packed {
    logic valid;
    logic [31:0] data;
  } oir_id_load_type;

endpackage
`default_nettype wire

// file: logic/oir_regs.sv
// node id low half, rom base mapping, failed-write capture, org code
// assumes a one-cycle strobe register port on clk and an external
// serial eeprom loader plus firmware loader for the unique node id
//
// Design decision made here: the address-and-strobe port.
`timescale 1ns/1ns
`default_nettype none

////////////////////////////////////////////////////////////////////////
// How it works
// - id low reads as a fixed 32-bit value, zero after reset
// - id low loads and locks together with the upper id half
// - eeprom loads id if present, else firmware; then frozen
// - in-window rom quadlet read: host address = base plus low ten bits
// - software writes base bits 31..10; bits 9..0 always read zero
// - rom base mapping resets to zero
// - failed posted write stores low 32 destination offset bits
// - failed posted write stores bus number and node number high
// - failed posted write stores upper 16 offset bits in low half
// - capture registers change only on posted-write failures
// - fixed read-only organisation code register
module oir_regs
  import oir_pkg::*;
#(
  parameter logic [31:0] ORG_CODE = 32'h0a5c_3e71 // arbitrary value
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata,
  input wire logic eeprom_present,
  input wire oir_id_load_type eeprom_load,
  input wire oir_id_load_type fw_load,
  output logic unique_node_id_locked,
  input wire oir_rom_req_type rom_req,
  output logic rom_host_valid,
  output logic [DATA_W-1:0] rom_host_addr,
  input wire oir_fail_type posted_fail
);

  //////////////////////////////////////////////////////////////////////
  // declarations
  logic [2:0] present_sync_ff;
  logic present_ff;
  logic nxt_present;
  logic id_locked_ff;
  logic [31:0] unique_id_low_ff;
  logic [31:0] nxt_unique_id_low;
  logic [ROM_FIELD_W-1:0] rom_base_field_ff;
  logic [31:0] dest_offset_lower_ff;
  oir_fail_high_type fail_high_ff;
  logic rom_valid_ff;
  logic [31:0] rom_addr_ff;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;
  logic [31:0] rom_map_word;
  logic [31:0] rom_sum;
  logic [31:0] read_sel;
  logic hit_uid;
  logic hit_map;
  logic hit_fail_low;
  logic hit_fail_high;
  logic hit_org;
  logic wr_map;
  logic eeprom_take;
  logic fw_take;
  logic id_take;
  logic rom_in_win;

  //////////////////////////////////////////////////////////////////////
  // eeprom strap pin: three flops, accept a change when 2nd and 3rd agree
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      present_sync_ff <= 3'h0;
      present_ff <= 1'b0;
    end else begin
      present_sync_ff <= {present_sync_ff[1:0], eeprom_present};
      present_ff <= nxt_present;
    end
  end

  assign nxt_present = (present_sync_ff[1] == present_sync_ff[2]) ?
                       present_sync_ff[2] : present_ff;

  //////////////////////////////////////////////////////////////////////
  // id load source select and lock
  assign eeprom_take = eeprom_load.valid && present_ff && !id_locked_ff;
  assign fw_take = fw_load.valid && !present_ff && !id_locked_ff;
  assign id_take = eeprom_take || fw_take;
  assign nxt_unique_id_low = eeprom_take ? eeprom_load.data :
                             fw_take ? fw_load.data : unique_id_low_ff;
  assign unique_node_id_locked = id_locked_ff; // shared with upper half

  // id low register: zero on reset, frozen after the first load
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      unique_id_low_ff <= UID_LOW_RST;
      id_locked_ff <= 1'b0;
    end else begin
      unique_id_low_ff <= nxt_unique_id_low;
      id_locked_ff <= id_locked_ff || id_take;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // register address decode
  assign hit_uid = (reg_addr == OFS_UID_LOW);
  assign hit_map = (reg_addr == OFS_ROM_MAP);
  assign hit_fail_low = (reg_addr == OFS_FAIL_LOW);
  assign hit_fail_high = (reg_addr == OFS_FAIL_HIGH);
  assign hit_org = (reg_addr == OFS_ORG_CODE);
  assign wr_map = reg_wr && hit_map;

  // rom mapping field: upper 22 bits writable, low 10 stay zero
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rom_base_field_ff <= ROM_MAP_RST[31:ROM_FIELD_LSB];
    end else if (wr_map) begin
      rom_base_field_ff <= reg_wdata[31:ROM_FIELD_LSB];
    end
  end

  assign rom_map_word = {rom_base_field_ff, ROM_LOW_ZERO};

  //////////////////////////////////////////////////////////////////////
  // config rom quadlet read translation
  assign rom_in_win = rom_req.valid && (rom_req.offset >= ROM_WIN_LO) &&
                      (rom_req.offset <= ROM_WIN_HI);
  assign rom_sum = rom_map_word +
                   {{(32-ROM_IDX_W){1'b0}}, rom_req.offset[ROM_IDX_W-1:0]};

  // host address pulse one cycle after an in-window request
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rom_valid_ff <= 1'b0;
      rom_addr_ff <= ROM_MAP_RST;
    end else begin
      rom_valid_ff <= rom_in_win;
      if (rom_in_win) begin
        rom_addr_ff <= rom_sum;
      end
    end
  end

  assign rom_host_valid = rom_valid_ff;
  assign rom_host_addr = rom_addr_ff;

  //////////////////////////////////////////////////////////////////////
  // failed posted write capture, updated only by the error event
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      dest_offset_lower_ff <= FAIL_RST;
      fail_high_ff <= FAIL_RST;
    end else if (posted_fail.valid) begin
      dest_offset_lower_ff <= posted_fail.offset[31:0];
      fail_high_ff.bus_num <= posted_fail.bus_num;
      fail_high_ff.node_num <= posted_fail.node_num;
      fail_high_ff.dest_offset_upper <= posted_fail.offset[47:32];
    end
  end

  //////////////////////////////////////////////////////////////////////
  // read mux; writes to read-only offsets fall through unused
  assign read_sel = hit_uid ? unique_id_low_ff :
                    hit_map ? rom_map_word :
                    hit_fail_low ? dest_offset_lower_ff :
                    hit_fail_high ? fail_high_ff :
                    hit_org ? ORG_CODE :
                    RD_UNMAPPED;
  assign nxt_rdata = reg_rd ? read_sel : RD_UNMAPPED;

  // read data one cycle after the read strobe
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata_ff <= RD_UNMAPPED;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign reg_rdata = rdata_ff;

  //////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_rom_hit;
    rom_req.valid && rom_req.offset >= ROM_WIN_LO &&
    rom_req.offset <= ROM_WIN_HI;
  endsequence

  sequence s_map_write;
    reg_wr && reg_addr == OFS_ROM_MAP;
  endsequence

  sequence s_read_of(logic [7:0] ofs);
    reg_rd && reg_addr == ofs;
  endsequence

  chk_id_reset_zero: assert property (
    $past(!rst_n) |-> unique_id_low_ff == 32'h0000_0000 && !id_locked_ff)
    else $error("id low not zero after reset");

  chk_id_load_lock: assert property (
    eeprom_load.valid && present_ff && !id_locked_ff |=>
      id_locked_ff && unique_id_low_ff == $past(eeprom_load.data))
    else $error("eeprom load did not fill and lock id");

  chk_id_frozen: assert property (
    id_locked_ff |=> id_locked_ff && $stable(unique_id_low_ff))
    else $error("id changed after lock");

  chk_fw_blocked: assert property (
    present_ff && !eeprom_load.valid && !id_locked_ff |=>
      $stable(unique_id_low_ff))
    else $error("firmware load taken with eeprom present");

  chk_rom_sum: assert property (
    s_rom_hit |=> rom_host_valid &&
      rom_host_addr == $past(rom_map_word) + $past(rom_req.offset[9:0]))
    else $error("rom host address wrong");

  chk_rom_outside: assert property (
    !rom_in_win |=> !rom_host_valid)
    else $error("rom address issued outside window");

  chk_map_write: assert property (
    s_map_write ##1 s_read_of(OFS_ROM_MAP) |=>
      reg_rdata == {$past(reg_wdata[31:10], 2), 10'h000})
    else $error("rom mapping write or readback wrong");

  chk_map_reset: assert property (
    $past(!rst_n) |-> rom_map_word == 32'h0000_0000)
    else $error("rom mapping not zero after reset");

  chk_fail_capture: assert property (
    posted_fail.valid |=> dest_offset_lower_ff == $past(posted_fail.offset[31:0])
      && fail_high_ff == {$past(posted_fail.bus_num),
      $past(posted_fail.node_num), $past(posted_fail.offset[47:32])})
    else $error("failed write not captured");

  chk_fail_hold: assert property (
    !posted_fail.valid |=> $stable(dest_offset_lower_ff) &&
      $stable(fail_high_ff))
    else $error("capture changed without failure");

  chk_org_read: assert property (
    s_read_of(OFS_ORG_CODE) |=> reg_rdata == ORG_CODE)
    else $error("organisation code read wrong");

  chk_ro_ignore: assert property (
    reg_wr && reg_addr != OFS_ROM_MAP |=> $stable(rom_base_field_ff))
    else $error("write to other offset changed mapping");

  chk_fail_read_high: assert property (
    s_read_of(OFS_FAIL_HIGH) |=> reg_rdata == $past(fail_high_ff))
    else $error("capture high read wrong");

  // read-back, load-source, strap filter and hold checks
  chk_id_read: assert property (
    s_read_of(OFS_UID_LOW) |=>
      reg_rdata == $past(unique_id_low_ff))
    else $error("id low read wrong");

  chk_fw_load: assert property (
    fw_load.valid && !present_ff && !id_locked_ff |=>
      id_locked_ff && unique_id_low_ff == $past(fw_load.data))
    else $error("firmware load did not fill and lock id");

  chk_ee_refused: assert property (
    eeprom_load.valid && !present_ff && !fw_load.valid && !id_locked_ff
      |=> !id_locked_ff && $stable(unique_id_low_ff))
    else $error("eeprom load taken with no eeprom fitted");

  chk_present_filter: assert property (
    present_sync_ff[1] != present_sync_ff[2] |=>
      $stable(present_ff))
    else $error("strap level accepted before flops agree");

  chk_rom_hold: assert property (
    !rom_in_win |=>
      $stable(rom_host_addr))
    else $error("rom host address moved without a hit");

  chk_map_update: assert property (
    s_map_write |=>
      rom_map_word == {$past(reg_wdata[31:10]), 10'h000})
    else $error("rom mapping write not stored");

  chk_fail_read_low: assert property (
    s_read_of(OFS_FAIL_LOW) |=>
      reg_rdata == $past(dest_offset_lower_ff))
    else $error("capture low read wrong");

  chk_id_write_ignored: assert property (
    reg_wr && reg_addr == OFS_UID_LOW && !id_take |=>
      $stable(unique_id_low_ff))
    else $error("write to id low changed it");

  chk_unmapped_zero: assert property (
    reg_rd && !(hit_uid || hit_map || hit_fail_low || hit_fail_high ||
      hit_org) |=> reg_rdata == RD_UNMAPPED)
    else $error("unmapped read not zero");

endmodule
`default_nettype wire

// file: verif/oir_regs_tb.sv
// self-checking bench for the node id, rom map and capture bank
// assumes oir_pkg and oir_regs compiled first; one 50 MHz clock
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import oir_pkg::*;
  localparam logic [31:0] ORG = 32'h5e1d_0b7a; // arbitrary value
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic eeprom_present = 1'b0;
  oir_id_load_type eeprom_load = '0;
  oir_id_load_type fw_load = '0;
  logic locked;
  oir_rom_req_type rom_req = '0;
  logic rom_host_valid;
  logic [31:0] rom_host_addr;
  oir_fail_type posted_fail = '0;
  int error_cnt = 0;
  int n_checks = 0;
  int cycles = 0;
  logic [31:0] m_map, m_addr, w;
  logic [47:0] offs[$];
  logic [7:0] ro_ofs[5] = '{8'h28, 8'h38, 8'h3c, 8'h40, 8'h44};

  always #10 clk = ~clk;

  oir_regs #(.ORG_CODE(ORG)) i_dut (
    .clk(clk),
    .rst_n(rst_n),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .eeprom_present(eeprom_present),
    .eeprom_load(eeprom_load),
    .fw_load(fw_load),
    .unique_node_id_locked(locked),
    .rom_req(rom_req),
    .rom_host_valid(rom_host_valid),
    .rom_host_addr(rom_host_addr),
    .posted_fail(posted_fail)
  );

  ////////////////////////////////////////////////////////////////////////
  // compare, verdict, hang guard
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic summarize();
    $display("checks=%0d errors=%0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      error_cnt++;
      summarize();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // bus and event drivers
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  // write then read back with no gap between the strobes
  task automatic wrc(input logic [7:0] a, input logic [31:0] d,
                     input logic [31:0] exp);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask

  // read data stands in the cycle after the strobe
  task automatic rc(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask

  task automatic ld(input bit ee, input logic [31:0] d, input bit lk);
    @(posedge clk);
    if (ee) begin
      eeprom_load <= {1'b1, d};
    end else begin
      fw_load <= {1'b1, d};
    end
    @(posedge clk);
    eeprom_load <= '0;
    fw_load <= '0;
    #1 chk({31'h0, locked}, {31'h0, lk});
  endtask

  task automatic rq(input logic [47:0] o);
    logic hit;
    hit = (o >= ROM_WIN_LO) && (o <= ROM_WIN_HI);
    if (hit) begin
      m_addr = m_map + {22'h0, o[9:0]};
    end
    @(posedge clk);
    rom_req <= {1'b1, o};
    @(posedge clk);
    rom_req <= '0;
    #1 chk({31'h0, rom_host_valid}, {31'h0, hit});
    chk(rom_host_addr, m_addr);
  endtask

  task automatic pf(input logic [9:0] b, input logic [5:0] n,
                    input logic [47:0] o);
    @(posedge clk);
    posted_fail <= {1'b1, b, n, o};
    @(posedge clk);
    posted_fail <= '0;
    rc(8'h38, o[31:0]);
    rc(8'h3c, {b, n, o[47:32]});
  endtask

  ////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    void'($urandom(32'hde607ce9));
    m_map = 32'h0;
    m_addr = 32'h0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    rc(8'h28, 32'h0);
    rc(8'h34, 32'h0);
    rc(8'h38, 32'h0);
    rc(8'h2c, 32'h0);
    rc(8'h40, ORG);
    @(posedge clk);
    #1 chk(reg_rdata, 32'h0);
    // read-only places keep their values
    foreach (ro_ofs[i]) begin
      wr(ro_ofs[i], $urandom);
    end
    rc(8'h28, 32'h0);
    rc(8'h3c, 32'h0);
    rc(8'h40, ORG);
    rc(8'h44, 32'h0);
    // base field writable, low ten bits zero
    repeat (4) begin
      w = $urandom;
      m_map = w & 32'hffff_fc00;
      wrc(8'h34, w, m_map);
    end
    offs = {ROM_WIN_LO - 48'h1, ROM_WIN_LO, ROM_WIN_HI, ROM_WIN_HI + 48'h1};
    repeat (6) begin
      w = $urandom;
      offs.push_back(ROM_WIN_LO | {38'h0, w[9:0]});
      offs.push_back({w, 16'h0});
    end
    foreach (offs[i]) begin
      rq(offs[i]);
    end
    // firmware path while no eeprom is fitted
    ld(1'b1, 32'h1111_2222, 1'b0);
    rc(8'h28, 32'h0);
    ld(1'b0, 32'hc0de_0001, 1'b1);
    ld(1'b0, 32'hc0de_0002, 1'b1);
    rc(8'h28, 32'hc0de_0001);
    wr(8'h28, 32'hffff_ffff);
    rc(8'h28, 32'hc0de_0001);
    w = $urandom;
    pf(10'h3a5, 6'h2c, {w[15:0], $urandom});
    pf(10'h001, 6'h3f, 48'hffff_0000_1234);
    wr(8'h38, 32'h0);
    rc(8'h38, 32'h0000_1234);
    // second reset with eeprom fitted
    @(posedge clk);
    rst_n <= 1'b0;
    eeprom_present <= 1'b1;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    m_map = 32'h0;
    m_addr = 32'h0;
    rc(8'h34, 32'h0);
    rc(8'h28, 32'h0);
    repeat (4) @(posedge clk);
    rq(ROM_WIN_HI);
    ld(1'b0, 32'h3333_4444, 1'b0);
    ld(1'b1, 32'hbeef_0003, 1'b1);
    ld(1'b1, 32'hbeef_0004, 1'b1);
    rc(8'h28, 32'hbeef_0003);
    summarize();
  end
endmodule
`default_nettype wire
